/* File: hw/ctdp_pkg.sv */
// Register map, field layout, mode codes and prescaler decode of the timer block
package ctdp_pkg;

  localparam int          ADDR_W       = 5;
  localparam int          PRE_W        = 11;

  // Byte offsets on the register bus
  localparam logic [4:0]  OFS_LOW_CTRL = 5'h00;
  localparam logic [4:0]  OFS_UP_CTRL  = 5'h04;
  localparam logic [4:0]  OFS_CMP_LOW  = 5'h08;
  localparam logic [4:0]  OFS_CMP_HIGH = 5'h0c;
  localparam logic [4:0]  OFS_DUTY     = 5'h10;
  localparam logic [4:0]  OFS_STATUS   = 5'h14;

  // Control register fields
  localparam int          CTL_FLOP_BIT = 7;
  localparam int          CTL_CLK_LSB  = 4;
  localparam int          CTL_RUN_BIT  = 3;
  localparam int          CTL_MODE_LSB = 0;

  // Operating modes held in the mode field of the upper control register
  localparam logic [2:0]  MODE_DIVIDER = 3'h1;
  localparam logic [2:0]  MODE_PWM     = 3'h2;
  localparam logic [2:0]  MODE_TIMER16 = 3'h4;

  // Reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  CMP_RST      = 8'h00;
  localparam logic [7:0]  DUTY_RST     = 8'h00;

  // Internal clock tick from the free prescaler for a clock select code
  function automatic logic ctdp_tick(input logic [2:0] sel, input logic [PRE_W-1:0] pre);
    logic t;
    t = 1'b1;
    case (sel)
      3'h0:    t = &pre[10:0];
      3'h1:    t = &pre[6:0];
      3'h2:    t = &pre[4:0];
      3'h3:    t = &pre[2:0];
      3'h4:    t = pre[0];
      default: t = 1'b1;
    endcase
    return t;
  endfunction : ctdp_tick

endpackage : ctdp_pkg

/* File: hw/ctdp_timer.sv */
// Cascadable timer with divider output, 8-bit PWM and 16-bit compare modes
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module ctdp_timer
  import ctdp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  output logic                   divider_out_pin,
  output logic                   pwm_out_pin,
  output logic                   counter_match_irq,
  output logic                   upper_match_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]       lower_counter_control_reg;
  logic [7:0]       upper_counter_control_reg;
  logic [15:0]      compare_period_reg;
  logic [7:0]       compare_low_pending;
  logic [7:0]       pwm_duty_stage;
  logic [7:0]       pwm_duty_reg;
  logic [15:0]      count;
  logic [PRE_W-1:0] prescale;
  logic             out_flop;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire              bus_wr     = write & ~waitrequest & byteenable[0];
  wire              bus_rd_cap = read & waitrequest;
  wire [7:0]        wd         = writedata[7:0];
  wire              wr_low     = bus_wr & (address == OFS_LOW_CTRL);
  wire              wr_up      = bus_wr & (address == OFS_UP_CTRL);
  wire              wr_cmp_lo  = bus_wr & (address == OFS_CMP_LOW);
  wire              wr_cmp_hi  = bus_wr & (address == OFS_CMP_HIGH);
  wire              wr_duty    = bus_wr & (address == OFS_DUTY);

  wire [31:0]       rd_val =
    (address == OFS_LOW_CTRL) ? {24'h000000, lower_counter_control_reg} :
    (address == OFS_UP_CTRL)  ? {24'h000000, upper_counter_control_reg} :
    (address == OFS_CMP_LOW)  ? {24'h000000, compare_period_reg[7:0]} :
    (address == OFS_CMP_HIGH) ? {24'h000000, compare_period_reg[15:8]} :
    (address == OFS_DUTY)     ? {24'h000000, pwm_duty_reg} :
    (address == OFS_STATUS)   ? {15'h0000, out_flop, count} :
    32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and timing decode
  wire [2:0]        mode       = upper_counter_control_reg[CTL_MODE_LSB +: 3];
  wire              run        = upper_counter_control_reg[CTL_RUN_BIT];
  wire              mode_div   = (mode == MODE_DIVIDER);
  wire              mode_pwm   = (mode == MODE_PWM);
  wire              mode_t16   = (mode == MODE_TIMER16);
  wire [2:0]        clk_sel    = mode_t16 ? lower_counter_control_reg[CTL_CLK_LSB +: 3]
                                          : upper_counter_control_reg[CTL_CLK_LSB +: 3];
  wire              step       = run & ctdp_tick(clk_sel, prescale);
  wire [15:0]       count_inc  = count + 16'h0001;
  wire [15:0]       count_step = mode_t16 ? count_inc : {8'h00, count_inc[7:0]};

  // Divider match against the unbuffered upper compare byte
  wire              div_hit    = step & mode_div & (count_inc[7:0] == compare_period_reg[15:8]);
  wire              pwm_ovf    = step & mode_pwm & (count[7:0] == 8'hff);
  wire              pwm_duty   = step & mode_pwm & ~pwm_ovf & (count_inc[7:0] == pwm_duty_reg);
  wire              t16_hit    = step & mode_t16 & (count_inc == compare_period_reg);
  wire              start      = wr_up & wd[CTL_RUN_BIT] & ~run;

  ////////////////////////////////////////////////////////////////////////////////
  // Next values
  wire              flop_load  = wr_up & ~run;
  wire              toggle     = div_hit | pwm_duty | pwm_ovf;
  wire              next_flop  = flop_load ? wd[CTL_FLOP_BIT] : (out_flop ^ toggle);
  wire [2:0]        next_mode  = wr_up ? wd[CTL_MODE_LSB +: 3] : mode;
  wire [15:0]       next_count = (start | div_hit | pwm_ovf | t16_hit) ? 16'h0000 :
                                 step ? count_step : count;
  wire [7:0]        next_stage = wr_duty ? wd : pwm_duty_stage;
  wire              duty_xfer  = pwm_ovf | (wr_duty & ~run);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus slave, one wait cycle per access
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end
    else
    begin
      waitrequest <= ~((read | write) & waitrequest);
      if (bus_rd_cap)
        readdata <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and compare registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lower_counter_control_reg <= CTRL_RST;
      upper_counter_control_reg <= CTRL_RST;
      compare_period_reg        <= {CMP_RST, CMP_RST};
      compare_low_pending       <= CMP_RST;
    end
    else
    begin
      if (wr_low)
        lower_counter_control_reg <= wd;
      if (wr_up)
        upper_counter_control_reg <= wd;
      if (wr_cmp_lo)
        compare_low_pending <= wd;
      if (wr_cmp_hi)
        compare_period_reg <= {wd, compare_low_pending};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Duty buffer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pwm_duty_stage <= DUTY_RST;
      pwm_duty_reg   <= DUTY_RST;
    end
    else
    begin
      pwm_duty_stage <= next_stage;
      if (duty_xfer)
        pwm_duty_reg <= next_stage;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter, prescaler and output flop
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count    <= 16'h0000;
      prescale <= '0;
      out_flop <= 1'b0;
    end
    else
    begin
      count    <= next_count;
      prescale <= prescale + 11'h001;
      out_flop <= next_flop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins and interrupt requests
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      divider_out_pin   <= 1'b1;
      pwm_out_pin       <= 1'b1;
      counter_match_irq <= 1'b0;
      upper_match_irq   <= 1'b0;
    end
    else
    begin
      divider_out_pin   <= (next_mode == MODE_DIVIDER) ? ~next_flop : 1'b1;
      pwm_out_pin       <= (next_mode == MODE_PWM) ? ~next_flop : 1'b1;
      counter_match_irq <= div_hit | pwm_ovf;
      upper_match_irq   <= t16_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_div_match_effects: assert property (
    @(posedge clk) disable iff (srst)
    div_hit & ~flop_load |=> (out_flop == ~$past(out_flop)) && (count == 16'h0000) && counter_match_irq)
    else $error("divider match did not toggle, clear and request");

  a_div_pin_inverse: assert property (
    @(posedge clk) disable iff (srst)
    mode_div |-> divider_out_pin == ~out_flop)
    else $error("divider pin is not the inverse of the flop");

  a_flop_reset_zero: assert property (
    @(posedge clk)
    $fell(srst) |-> !out_flop && divider_out_pin && pwm_out_pin)
    else $error("flop not cleared by reset");

  a_stopped_pin_hold: assert property (
    @(posedge clk) disable iff (srst)
    !run && !wr_up ##1 !run && !wr_up |-> $stable(out_flop) && $stable(count))
    else $error("stopped counter changed flop or count");

  a_pwm_duty_toggle: assert property (
    @(posedge clk) disable iff (srst)
    pwm_duty & ~flop_load |=> (out_flop != $past(out_flop)) && (count != 16'h0000) && !counter_match_irq)
    else $error("pwm duty match misbehaved");

  a_pwm_overflow: assert property (
    @(posedge clk) disable iff (srst)
    pwm_ovf & ~wr_duty |=> count == 16'h0000 && counter_match_irq && pwm_duty_reg == $past(pwm_duty_stage))
    else $error("pwm overflow did not clear, request and reload duty");

  a_pwm_pin_inverse: assert property (
    @(posedge clk) disable iff (srst)
    mode_pwm |-> pwm_out_pin == ~out_flop)
    else $error("pwm pin is not the inverse of the flop");

  a_duty_staged: assert property (
    @(posedge clk) disable iff (srst)
    wr_duty & run & ~pwm_ovf |=> pwm_duty_reg == $past(pwm_duty_reg))
    else $error("running duty write took effect before overflow");

  a_duty_read_active: assert property (
    @(posedge clk) disable iff (srst)
    bus_rd_cap && address == OFS_DUTY |=> readdata[7:0] == $past(pwm_duty_reg))
    else $error("duty read did not return the active value");

  a_t16_match: assert property (
    @(posedge clk) disable iff (srst)
    t16_hit |=> upper_match_irq && count == 16'h0000 && !counter_match_irq)
    else $error("16-bit match did not clear and request");

  a_cmp_low_pending: assert property (
    @(posedge clk) disable iff (srst)
    wr_cmp_lo |=> $stable(compare_period_reg) && (compare_low_pending == $past(writedata[7:0])))
    else $error("low compare byte applied without the high byte");

  a_bus_answer: assert property (
    @(posedge clk) disable iff (srst)
    (read | write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus access not answered in one cycle");

  a_cmp_high_apply: assert property (
    @(posedge clk) disable iff (srst)
    wr_cmp_hi |=> compare_period_reg == {$past(writedata[7:0]), $past(compare_low_pending)})
    else $error("high compare byte did not apply both bytes together");

  a_cmp_high_read: assert property (
    @(posedge clk) disable iff (srst)
    bus_rd_cap && address == OFS_CMP_HIGH |=> readdata[7:0] == $past(compare_period_reg[15:8]))
    else $error("compare high read did not return the applied value");

  a_div_idle_high: assert property (
    @(posedge clk) disable iff (srst)
    !mode_div |-> divider_out_pin)
    else $error("divider pin not idle high outside divider mode");

  a_pwm_idle_high: assert property (
    @(posedge clk) disable iff (srst)
    !mode_pwm |-> pwm_out_pin)
    else $error("pwm pin not idle high outside pwm mode");

  a_div_hold_stopped: assert property (
    @(posedge clk) disable iff (srst)
    mode_div && !run && !wr_up |=> $stable(divider_out_pin))
    else $error("stopped divider pin changed");

  a_pwm_hold_stopped: assert property (
    @(posedge clk) disable iff (srst)
    mode_pwm && !run && !wr_up |=> $stable(pwm_out_pin))
    else $error("stopped pwm pin changed");

  a_stop_keeps_flop: assert property (
    @(posedge clk) disable iff (srst)
    wr_up && run && !step |=> $stable(out_flop))
    else $error("write while running loaded the flop");

  a_flop_load: assert property (
    @(posedge clk) disable iff (srst)
    wr_up && !run |=> out_flop == $past(writedata[CTL_FLOP_BIT]))
    else $error("stopped control write did not load the flop");

  a_duty_load_stopped: assert property (
    @(posedge clk) disable iff (srst)
    wr_duty && !run |=> pwm_duty_reg == $past(writedata[7:0]))
    else $error("stopped duty write did not take effect at once");

  a_div_count_up: assert property (
    @(posedge clk) disable iff (srst)
    mode_div && step && !div_hit |=> count[7:0] == $past(count[7:0]) + 8'h01)
    else $error("divider counter did not count up");

  a_pwm_count_up: assert property (
    @(posedge clk) disable iff (srst)
    mode_pwm && step && !pwm_ovf |=> count[7:0] == $past(count[7:0]) + 8'h01)
    else $error("pwm counter did not keep counting");

  a_t16_count_up: assert property (
    @(posedge clk) disable iff (srst)
    mode_t16 && step && !t16_hit |=> count == $past(count) + 16'h0001)
    else $error("16-bit counter did not count up");

  a_start_clears: assert property (
    @(posedge clk) disable iff (srst)
    wr_up && writedata[CTL_RUN_BIT] && !run |=> count == 16'h0000)
    else $error("start did not clear the counter");

  a_match_irq_source: assert property (
    @(posedge clk) disable iff (srst)
    counter_match_irq |-> $past(div_hit) || $past(pwm_ovf))
    else $error("match request without divider match or pwm overflow");

  a_upper_irq_source: assert property (
    @(posedge clk) disable iff (srst)
    upper_match_irq |-> $past(t16_hit))
    else $error("upper request without 16-bit match");

endmodule : ctdp_timer

/* File: dv/tb_top.sv */
// Self-checking bench for the cascadable timer: bus access, divider, PWM and 16-bit modes
`timescale 1ns/100ps

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module tb_top
  import ctdp_pkg::*;
;
  logic              clk;
  logic              srst;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic              divider_out_pin;
  logic              pwm_out_pin;
  logic              counter_match_irq;
  logic              upper_match_irq;
  int                miscompares;
  int                checks_done;
  int                n;
  int                n2;
  logic              p;
  logic [31:0]       rd;

  ctdp_timer dut (
    .clk               (clk),
    .srst              (srst),
    .address           (address),
    .read              (read),
    .write             (write),
    .writedata         (writedata),
    .byteenable        (byteenable),
    .readdata          (readdata),
    .waitrequest       (waitrequest),
    .divider_out_pin   (divider_out_pin),
    .pwm_out_pin       (pwm_out_pin),
    .counter_match_irq (counter_match_irq),
    .upper_match_irq   (upper_match_irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, verdict and bus tasks
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // Holds the request until waitrequest is sampled low, then releases it
  task bus_access(input logic [ADDR_W-1:0] a, input logic wr, input logic [7:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    address   <= a;
    read      <= ~wr;
    write     <= wr;
    writedata <= {24'h0, d};
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (k >= 50)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask : bus_access

  task bus_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_access(a, 1'b1, d, q);
  endtask : bus_write

  task bus_read(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    bus_access(a, 1'b0, 8'h00, q);
  endtask : bus_read

  // Counts edges until the chosen output is sampled at the given level
  task wait_sig(input int sel, input logic lvl, output int cnt);
    logic v;
    cnt = 0;
    do
    begin
      @(posedge clk);
      cnt++;
      v = (sel == 0) ? counter_match_irq : (sel == 1) ? upper_match_irq :
          (sel == 2) ? divider_out_pin : pwm_out_pin;
    end
    while (v !== lvl && cnt < 2000);
    if (cnt >= 2000)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask : wait_sig

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial
  begin
    miscompares = 0;
    checks_done = 0;
    srst        = 1'b1;
    address     = '0;
    read        = 1'b0;
    write       = 1'b0;
    writedata   = '0;
    byteenable  = 4'h1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Reset state, and an unmapped place reads zero
    `CHK(divider_out_pin, 1'b1)
    `CHK(pwm_out_pin, 1'b1)
    for (int a = 0; a <= 24; a += 4)
    begin
      bus_read(a[ADDR_W-1:0], rd);
      `CHK(rd, 32'h0)
    end
    // A write with the low byte lane off is ignored
    byteenable <= 4'h0;
    bus_write(OFS_DUTY, 8'h55);
    byteenable <= 4'h1;
    bus_read(OFS_DUTY, rd);
    `CHK(rd, 32'h0)
    // Divider: half period of six ticks at the fastest clock select; port latch is outside
    bus_write(OFS_CMP_LOW, 8'h06);
    bus_write(OFS_CMP_HIGH, 8'h06);
    bus_write(OFS_UP_CTRL, 8'h51);
    bus_write(OFS_UP_CTRL, 8'h59);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b1, n);
    `CHK(n, 6)
    p = divider_out_pin;
    wait_sig(2, ~p, n);
    wait_sig(2, p, n);
    `CHK(n, 6)
    wait_sig(2, ~p, n);
    `CHK(n, 6)
    // Divide-by-eight clock select: six ticks of eight clocks
    bus_write(OFS_UP_CTRL, 8'h31);
    bus_write(OFS_UP_CTRL, 8'h39);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b1, n);
    `CHK(n, 48)
    // Stop holds the pin; a later write loads the flop
    bus_write(OFS_UP_CTRL, 8'h51);
    @(posedge clk);
    p = divider_out_pin;
    repeat (20) @(posedge clk);
    `CHK(divider_out_pin, p)
    bus_read(OFS_STATUS, rd);
    `CHK(divider_out_pin, ~rd[16])
    bus_write(OFS_UP_CTRL, 8'hd1);
    repeat (2) @(posedge clk);
    `CHK(divider_out_pin, 1'b0)
    // Reset while stopped clears the loaded flop
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK(divider_out_pin, 1'b1)
    bus_read(OFS_STATUS, rd);
    `CHK(rd, 32'h0)
    // PWM: staged duty, read of active duty, duty and overflow toggles
    bus_write(OFS_UP_CTRL, 8'h52);
    bus_write(OFS_DUTY, 8'h40);
    bus_read(OFS_DUTY, rd);
    `CHK(rd[7:0], 8'h40)
    bus_write(OFS_UP_CTRL, 8'h5a);
    wait_sig(0, 1'b1, n);
    bus_write(OFS_DUTY, 8'h80);
    bus_read(OFS_DUTY, rd);
    `CHK(rd[7:0], 8'h40)
    wait_sig(0, 1'b1, n);
    bus_read(OFS_DUTY, rd);
    `CHK(rd[7:0], 8'h80)
    wait_sig(0, 1'b1, n);
    p = pwm_out_pin;
    wait_sig(3, ~p, n);
    `CHK(n, 128)
    wait_sig(0, 1'b1, n2);
    `CHK(n + n2, 256)
    @(posedge clk);
    `CHK(counter_match_irq, 1'b0)
    `CHK(divider_out_pin, 1'b1)
    bus_write(OFS_UP_CTRL, 8'h52);
    @(posedge clk);
    p = pwm_out_pin;
    repeat (300) @(posedge clk);
    `CHK(pwm_out_pin, p)
    bus_read(OFS_STATUS, rd);
    `CHK(pwm_out_pin, ~rd[16])
    // 16-bit timer clocked by the lower clock select, compare 0x0105
    bus_write(OFS_LOW_CTRL, 8'h50);
    bus_write(OFS_CMP_LOW, 8'h05);
    bus_write(OFS_CMP_HIGH, 8'h01);
    bus_write(OFS_UP_CTRL, 8'h04);
    bus_write(OFS_UP_CTRL, 8'h0c);
    wait_sig(1, 1'b1, n);
    wait_sig(1, 1'b1, n);
    `CHK(n, 261)
    // A lone low byte write stays pending
    bus_write(OFS_CMP_LOW, 8'h02);
    wait_sig(1, 1'b1, n);
    wait_sig(1, 1'b1, n);
    `CHK(n, 261)
    `CHK(pwm_out_pin, 1'b1)
    tally_and_finish();
  end
endmodule : tb_top
